//--- verilog/ogd_pkg.sv
package ogd_pkg;

    // Clock rate and timing constants
    localparam int CLK_MHZ         = 25;
    localparam int CLAMP_BYPASS_US = 15;
    localparam int CLAMP_BYPASS_CYC = CLAMP_BYPASS_US * CLK_MHZ;
    localparam int ACK_CYC_DEF     = 25;
    localparam int BLK_CYC_DEF     = 2500;
    localparam int RES_CYC_DEF     = 100;
    localparam int FOFF_CYC_DEF    = 10;
    localparam int BLANK_CYC_DEF   = 50;
    localparam int BOOST_CYC_DEF   = 200;
    localparam int RESTORE_CYC_DEF = 100;
    localparam int CNT_W           = 16;

    // Gate level encoding
    typedef enum logic [1:0] {
        OGD_GATE_OFF = 2'h0,
        OGD_GATE_10V = 2'h1,
        OGD_GATE_15V = 2'h2,
        OGD_GATE_25V = 2'h3
    } ogd_gate_t;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        OGD_OFF     = 6'h01,
        OGD_BOOST   = 6'h02,
        OGD_ON      = 6'h04,
        OGD_REDUCED = 6'h08,
        OGD_FTOFF   = 6'h10,
        OGD_BLOCK   = 6'h20
    } ogd_state_t;

    // Sense inputs travelling together
    typedef struct packed {
        logic supplyLow;
        logic slopeEvent;
        logic desatHigh;
        logic clampActive;
    } ogd_sense_t;

    // Whole module state
    typedef struct packed {
        ogd_state_t       st;
        logic [CNT_W-1:0] seqCnt;
        logic [CNT_W-1:0] resCnt;
        logic [CNT_W-1:0] blankCnt;
        logic [CNT_W-1:0] ackCnt;
        logic [CNT_W-1:0] clampCnt;
        logic             cmdPrev;
        logic             resDone;
        logic             statusLight;
        ogd_gate_t        gate;
        logic             turnOffEn;
        logic             clampStageEn;
    } ogd_regs_t;

endpackage : ogd_pkg

//--- verilog/ogd_fault_logic.sv
// Contract
// - Light on means on, off means off
// - Command edges launch switching actions
// - Status light on when healthy
// - Status light off during any fault
// - Each command edge outside a fault gives ack dark pulse
// - Undervoltage forces status dark, switch off
// - Commands ignored while fault is active
// - Turn-on at 15V, then 25V after boost
// - Slope event input flags type-two shorts
// - Slope detection masked after each turn-on
// - Slope event drops gate to 10V
// - Desat then off, else restore 25V
// - Sample desat after response time at turn-on
// - Short circuit: delayed off, fault signalled
// - Fault status clears after blocking time
// - Resume only on fresh on command
// - Clamp active disables turn-off transistor
// - Clamp stage bypassed for 15us after turn-off
// - Command light-off turns switch off
`timescale 1ns/1ps
module ogd_fault_logic
    import ogd_pkg::*;
#(
    // Every interval is a cycle count of the local clock
    parameter int ACK_CYC     = ACK_CYC_DEF,
    parameter int BLK_CYC     = BLK_CYC_DEF,
    parameter int RES_CYC     = RES_CYC_DEF,
    parameter int FOFF_CYC    = FOFF_CYC_DEF,
    parameter int BLANK_CYC   = BLANK_CYC_DEF,
    parameter int BOOST_CYC   = BOOST_CYC_DEF,
    parameter int RESTORE_CYC = RESTORE_CYC_DEF
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Optical link
    input  wire logic       cmdLight,
    output logic            statusLight,
    // Sense inputs from the power stage
    input  wire ogd_sense_t sense,
    // Gate stage controls
    output ogd_gate_t       gateLevel,
    output logic            turnOffEn,
    output logic            clampStageEn
);

    // Counters are CNT_W wide; larger counts cannot be served
    initial begin
        if (ACK_CYC < 1 || BLK_CYC < 1 || RES_CYC < 1 || FOFF_CYC < 1 ||
            BLANK_CYC < 1 || BOOST_CYC < 1 || RESTORE_CYC < 1 ||
            BLK_CYC >= (1 << CNT_W) || BOOST_CYC >= (1 << CNT_W) ||
            RESTORE_CYC >= (1 << CNT_W) || RES_CYC >= (1 << CNT_W) ||
            BLANK_CYC >= (1 << CNT_W) || ACK_CYC >= (1 << CNT_W) ||
            FOFF_CYC >= (1 << CNT_W) || CLAMP_BYPASS_CYC >= (1 << CNT_W)) begin
            $error("ogd_fault_logic: cycle count out of range");
        end
    end

    localparam logic [CNT_W-1:0] ACK_N     = CNT_W'(ACK_CYC);
    localparam logic [CNT_W-1:0] BLK_N     = CNT_W'(BLK_CYC);
    localparam logic [CNT_W-1:0] RES_N     = CNT_W'(RES_CYC);
    localparam logic [CNT_W-1:0] FOFF_N    = CNT_W'(FOFF_CYC);
    localparam logic [CNT_W-1:0] BLANK_N   = CNT_W'(BLANK_CYC);
    localparam logic [CNT_W-1:0] BOOST_N   = CNT_W'(BOOST_CYC);
    localparam logic [CNT_W-1:0] RESTORE_N = CNT_W'(RESTORE_CYC);
    localparam logic [CNT_W-1:0] CLAMP_N   = CNT_W'(CLAMP_BYPASS_CYC);
    localparam logic [CNT_W-1:0] ZERO      = '0;
    localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);

    ogd_regs_t r_q;
    ogd_regs_t r_d;

    logic cmdRise;
    logic cmdFall;
    logic faultActive;
    logic slopeSeen;
    logic desatSeen;

    // Edge detection on the command light
    assign cmdRise = cmdLight & ~r_q.cmdPrev;
    assign cmdFall = ~cmdLight & r_q.cmdPrev;
    // Fault covers undervoltage and the whole short-circuit sequence
    assign faultActive = sense.supplyLow || r_q.st == OGD_FTOFF || r_q.st == OGD_BLOCK;
    // Slope events count only once blanking has run out
    assign slopeSeen = sense.slopeEvent && r_q.blankCnt == ZERO;
    // Desaturation is sampled at the end of the response window, and watched
    // all through the reduced-gate phase so a slope event can end in turn-off
    assign desatSeen = sense.desatHigh &&
                       (r_q.resCnt == ONE || r_q.st == OGD_REDUCED);

    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.cmdPrev = cmdLight;
        if (r_q.seqCnt != ZERO) r_d.seqCnt = r_q.seqCnt - ONE;
        if (r_q.resCnt != ZERO) r_d.resCnt = r_q.resCnt - ONE;
        if (r_q.blankCnt != ZERO) r_d.blankCnt = r_q.blankCnt - ONE;
        if (r_q.ackCnt != ZERO) r_d.ackCnt = r_q.ackCnt - ONE;
        if (r_q.clampCnt != ZERO) r_d.clampCnt = r_q.clampCnt - ONE;
        if (r_q.resCnt == ONE) r_d.resDone = 1'b1;

        // Every edge is acknowledged unless a fault blanks the link anyway
        if ((cmdRise || cmdFall) && !faultActive) r_d.ackCnt = ACK_N;

        case (r_q.st)
            OGD_OFF: begin
                if (cmdRise) begin
                    r_d.st       = OGD_BOOST;
                    r_d.seqCnt   = BOOST_N;
                    r_d.resCnt   = RES_N;
                    r_d.resDone  = 1'b0;
                    r_d.blankCnt = BLANK_N;
                end
            end
            OGD_BOOST, OGD_ON, OGD_REDUCED: begin
                if (cmdFall) begin
                    r_d.st = OGD_OFF;
                end else if (desatSeen) begin
                    r_d.st     = OGD_FTOFF;
                    r_d.seqCnt = FOFF_N;
                end else if (slopeSeen && r_q.st != OGD_REDUCED) begin
                    r_d.st     = OGD_REDUCED;
                    r_d.seqCnt = RESTORE_N;
                end else if (r_q.seqCnt == ONE && r_q.st != OGD_ON) begin
                    r_d.st = OGD_ON;
                end
            end
            OGD_FTOFF: begin
                if (r_q.seqCnt == ONE) begin
                    r_d.st     = OGD_BLOCK;
                    r_d.seqCnt = BLK_N;
                end
            end
            OGD_BLOCK: begin
                if (r_q.seqCnt == ONE) r_d.st = OGD_OFF;
            end
            default: r_d.st = OGD_OFF;
        endcase

        // Undervoltage overrides everything and drops to off
        if (sense.supplyLow) r_d.st = OGD_OFF;
        // Commands arriving during a fault are simply dropped
        if (faultActive && r_d.st == OGD_BOOST) r_d.st = OGD_OFF;

        // Gate drive level from the next state
        case (r_d.st)
            OGD_BOOST:   r_d.gate = OGD_GATE_15V;
            OGD_ON:      r_d.gate = OGD_GATE_25V;
            OGD_REDUCED: r_d.gate = OGD_GATE_10V;
            OGD_FTOFF:   r_d.gate = r_q.gate;
            default:     r_d.gate = OGD_GATE_OFF;
        endcase

        // Bypass timer restarts on every transition into off
        if (r_d.gate == OGD_GATE_OFF && r_q.gate != OGD_GATE_OFF) r_d.clampCnt = CLAMP_N;
        r_d.clampStageEn = r_d.gate == OGD_GATE_OFF && r_d.clampCnt == ZERO;
        // Turn-off transistor yields to the clamp path
        r_d.turnOffEn = r_d.gate == OGD_GATE_OFF && !sense.clampActive;

        // Status light: dark on fault or during an ack pulse
        r_d.statusLight = !faultActive && !(r_d.st == OGD_FTOFF) &&
                          r_d.ackCnt == ZERO;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q.st           <= OGD_OFF;
            r_q.seqCnt       <= '0;
            r_q.resCnt       <= '0;
            r_q.blankCnt     <= '0;
            r_q.ackCnt       <= '0;
            r_q.clampCnt     <= '0;
            r_q.cmdPrev      <= 1'b0;
            r_q.resDone      <= 1'b0;
            r_q.statusLight  <= 1'b0;
            r_q.gate         <= OGD_GATE_OFF;
            r_q.turnOffEn    <= 1'b1;
            r_q.clampStageEn <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign statusLight  = r_q.statusLight;
    assign gateLevel    = r_q.gate;
    assign turnOffEn    = r_q.turnOffEn;
    assign clampStageEn = r_q.clampStageEn;

    // Checks
    chk_supply_undervoltage_lockout_dark: assert property (@(posedge clk) disable iff (!rst_n)
        sense.supplyLow |=> !statusLight && gateLevel == OGD_GATE_OFF)
        else $error("undervoltage did not force off and dark");
    chk_fault_dark: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == OGD_BLOCK |-> !statusLight)
        else $error("status light on while blocking");
    chk_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (cmdRise && !faultActive) |=> !statusLight)
        else $error("no ack pulse after edge");
    chk_boost_level: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == OGD_OFF && cmdRise && !faultActive) |=> gateLevel == OGD_GATE_15V)
        else $error("turn-on did not start at 15V");
    chk_fall_off: assert property (@(posedge clk) disable iff (!rst_n)
        (cmdFall && r_q.st != OGD_FTOFF && r_q.st != OGD_BLOCK) |=>
        gateLevel == OGD_GATE_OFF)
        else $error("light-off command did not turn off");
    chk_blank_mask: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.blankCnt != ZERO && sense.slopeEvent && !cmdFall && !desatSeen &&
         (r_q.st == OGD_BOOST || r_q.st == OGD_ON))
        |=> gateLevel != OGD_GATE_10V)
        else $error("slope acted on during blanking");
    // A slope event after blanking must drop the gate to the reduced level
    chk_slope_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (slopeSeen && !cmdFall && !desatSeen && !sense.supplyLow &&
         (r_q.st == OGD_BOOST || r_q.st == OGD_ON))
        |=> gateLevel == OGD_GATE_10V)
        else $error("slope event did not reduce gate");
    // Desaturation in the reduced phase leads into the fault turn-off
    chk_reduced_desat: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == OGD_REDUCED && sense.desatHigh && !cmdFall && !sense.supplyLow)
        |=> r_q.st == OGD_FTOFF)
        else $error("desaturation ignored while reduced");
    // Without desaturation the reduced phase ends back at full drive
    chk_restore_full: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == OGD_REDUCED && r_q.seqCnt == ONE && !sense.desatHigh &&
         !cmdFall && !sense.supplyLow)
        |=> gateLevel == OGD_GATE_25V)
        else $error("gate not restored after reduced phase");
    // The response-time sample declares the short circuit
    chk_desat_trip: assert property (@(posedge clk) disable iff (!rst_n)
        (desatSeen && !cmdFall && !sense.supplyLow &&
         (r_q.st == OGD_BOOST || r_q.st == OGD_ON))
        |=> r_q.st == OGD_FTOFF)
        else $error("short circuit not declared");
    // Fault turn-off delay keeps the status dark
    chk_ftoff_dark: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == OGD_FTOFF |-> !statusLight)
        else $error("status light on during fault turn-off");
    // Boost phase ends at full drive when nothing intervenes
    chk_boost_raise: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == OGD_BOOST && r_q.seqCnt == ONE && !cmdFall && !desatSeen &&
         !slopeSeen && !sense.supplyLow)
        |=> gateLevel == OGD_GATE_25V)
        else $error("boost did not raise gate to 25V");
    // A rising command during a fault never starts a turn-on
    chk_fault_noon: assert property (@(posedge clk) disable iff (!rst_n)
        (faultActive && cmdRise) |=> r_q.st != OGD_BOOST)
        else $error("turn-on started during fault");
    // Blocking ends by itself once its count runs out
    chk_block_exit: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == OGD_BLOCK && r_q.seqCnt == ONE) |=> r_q.st == OGD_OFF)
        else $error("blocking did not end");
    chk_block_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == OGD_BLOCK |=> gateLevel == OGD_GATE_OFF)
        else $error("gate driven during fault");
    chk_clamp_tof: assert property (@(posedge clk) disable iff (!rst_n)
        sense.clampActive |=> !turnOffEn)
        else $error("turn-off stage on while clamping");
    chk_clamp_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(gateLevel != OGD_GATE_OFF)) |-> !clampStageEn [*8])
        else $error("clamp stage enabled too early");
    chk_healthy_on: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == OGD_OFF && !sense.supplyLow && r_q.ackCnt == ZERO && !cmdRise && !cmdFall)
        |=> statusLight)
        else $error("status dark while healthy");

endmodule : ogd_fault_logic

//--- test/ogd_host_model.sv
`timescale 1ns/1ps
// Host controller: drives the command fibre and counts acknowledge pulses
module ogd_host_model (
    // Clock and intent
    input  wire logic  clk,
    input  wire logic  wantOn,
    // Fibre links
    input  wire logic  statusLight,
    output logic       cmdLight,
    output logic [7:0] ackSeen
);
    // Initialised at declaration so each variable has one process writing it
    logic       prevLight = 1'b0;
    logic [7:0] ackCount  = 8'h0;

    assign ackSeen = ackCount;
    // Light on asks for on, light off for off; moved off the sampling edge
    always @(negedge clk) cmdLight <= wantOn;
    // A dark edge on the status fibre is taken as one acknowledge
    always @(negedge clk) begin
        prevLight <= statusLight;
        if (prevLight && !statusLight) ackCount <= ackCount + 8'h1;
    end
endmodule : ogd_host_model

//--- test/ogd_fault_logic_test.sv
`timescale 1ns/1ps
module ogd_fault_logic_test;
    import ogd_pkg::*;
    // Short counts keep the run brief; boost outlasts response plus fault delay
    localparam int ACK = 4, BLK = 50, RES = 10, FOFF = 3, BLANK = 8, BOOST = 20, REST = 12;
    logic       clk, rst_n, wantOn, cmdLight, statusLight, turnOffEn, clampStageEn;
    logic [7:0] ackSeen;
    ogd_sense_t sense;
    ogd_gate_t  gateLevel;
    int         n_fail, n_compared, cycles, a, n;

    ogd_fault_logic #(.ACK_CYC(ACK), .BLK_CYC(BLK), .RES_CYC(RES), .FOFF_CYC(FOFF),
        .BLANK_CYC(BLANK), .BOOST_CYC(BOOST), .RESTORE_CYC(REST)) i_ogd_fault_logic (
        .clk(clk), .rst_n(rst_n), .cmdLight(cmdLight), .statusLight(statusLight),
        .sense(sense), .gateLevel(gateLevel), .turnOffEn(turnOffEn),
        .clampStageEn(clampStageEn));
    ogd_host_model i_ogd_host_model (.clk(clk), .wantOn(wantOn),
        .statusLight(statusLight), .cmdLight(cmdLight), .ackSeen(ackSeen));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic checkVal(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : checkVal

    // Durations are judged within one cycle of the target
    task automatic checkSpan(input string what, input int exp, input int seen);
        n_compared++;
        if (seen < exp - 1 || seen > exp + 1) begin
            n_fail++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : checkSpan

    task automatic waitGate(input logic [1:0] g);
        for (int i = 0; i < 1000 && gateLevel !== g; i++) @(negedge clk);
    endtask : waitGate

    task automatic spanOf(input logic [1:0] g, output int c);
        for (c = 0; c < 1000 && gateLevel === g; c++) @(negedge clk);
    endtask : spanOf

    task automatic testTurnOn;
        a = ackSeen;
        wantOn = 1'b1;
        waitGate(OGD_GATE_15V);
        checkVal("status", 16'h0, statusLight);
        spanOf(OGD_GATE_15V, n);
        checkSpan("boost", BOOST, n);
        checkVal("gate", OGD_GATE_25V, gateLevel);
        checkVal("status", 16'h1, statusLight);
        checkVal("acks", a + 1, ackSeen);
        $display("turn-on done");
    endtask : testTurnOn

    task automatic testSlope;
        sense.slopeEvent = 1'b1;
        waitGate(OGD_GATE_10V);
        sense.slopeEvent = 1'b0;
        checkVal("gate", OGD_GATE_10V, gateLevel);
        spanOf(OGD_GATE_10V, n);
        checkSpan("restore", REST, n);
        checkVal("gate", OGD_GATE_25V, gateLevel);
        $display("slope done");
    endtask : testSlope

    task automatic testSlopeDesat;
        sense.slopeEvent = 1'b1;
        waitGate(OGD_GATE_10V);
        sense.slopeEvent = 1'b0;
        sense.desatHigh = 1'b1;
        spanOf(OGD_GATE_10V, n);
        checkSpan("reduced off", FOFF + 1, n);
        checkVal("gate", OGD_GATE_OFF, gateLevel);
        checkVal("status", 16'h0, statusLight);
        sense.desatHigh = 1'b0;
        for (n = 0; n < 1000 && statusLight === 1'b0; n++) @(negedge clk);
        checkSpan("block", BLK + 1, n);
        wantOn = 1'b0;
        repeat (ACK + 3) @(negedge clk);
        $display("slope desaturation done");
    endtask : testSlopeDesat

    task automatic testTurnOff;
        a = ackSeen;
        wantOn = 1'b0;
        waitGate(OGD_GATE_OFF);
        checkVal("gate", OGD_GATE_OFF, gateLevel);
        for (n = 0; n < 1000 && clampStageEn === 1'b0; n++) @(negedge clk);
        checkSpan("bypass", CLAMP_BYPASS_CYC, n);
        checkVal("acks", a + 1, ackSeen);
        sense.clampActive = 1'b1;
        repeat (2) @(negedge clk);
        checkVal("turnoff", 16'h0, turnOffEn);
        sense.clampActive = 1'b0;
        repeat (2) @(negedge clk);
        checkVal("turnoff", 16'h1, turnOffEn);
        $display("turn-off done");
    endtask : testTurnOff

    task automatic testBlank;
        wantOn = 1'b1;
        sense.slopeEvent = 1'b1;
        waitGate(OGD_GATE_15V);
        repeat (BLANK - 3) @(negedge clk);
        checkVal("gate", OGD_GATE_15V, gateLevel);
        sense.slopeEvent = 1'b0;
        waitGate(OGD_GATE_25V);
        wantOn = 1'b0;
        waitGate(OGD_GATE_OFF);
        repeat (3) @(negedge clk);
        $display("blanking done");
    endtask : testBlank

    task automatic testDesat;
        sense.desatHigh = 1'b1;
        wantOn = 1'b1;
        waitGate(OGD_GATE_15V);
        spanOf(OGD_GATE_15V, n);
        checkSpan("fault off", RES + FOFF, n);
        checkVal("gate", OGD_GATE_OFF, gateLevel);
        sense.desatHigh = 1'b0;
        for (n = 0; n < 1000 && statusLight === 1'b0; n++) begin
            wantOn = (n < 5 || n > 15);
            @(negedge clk);
            if (n == 20) checkVal("gate", OGD_GATE_OFF, gateLevel);
        end
        checkSpan("block", BLK, n);
        repeat (5) @(negedge clk);
        checkVal("gate", OGD_GATE_OFF, gateLevel);
        wantOn = 1'b0;
        // Let the acknowledge of this fall finish before the next rise
        repeat (ACK + 3) @(negedge clk);
        testTurnOn();
        $display("desaturation done");
    endtask : testDesat

    task automatic testSupply;
        sense.supplyLow = 1'b1;
        waitGate(OGD_GATE_OFF);
        checkVal("status", 16'h0, statusLight);
        wantOn = 1'b0;
        repeat (3) @(negedge clk);
        wantOn = 1'b1;
        repeat (3) @(negedge clk);
        checkVal("gate", OGD_GATE_OFF, gateLevel);
        checkVal("status", 16'h0, statusLight);
        sense.supplyLow = 1'b0;
        $display("undervoltage done");
    endtask : testSupply

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Whole run needs about 700 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        wantOn = 1'b0;
        sense = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        checkVal("status", 16'h1, statusLight);
        testTurnOn();
        testSlope();
        testSlopeDesat();
        testTurnOn();
        testTurnOff();
        testBlank();
        testDesat();
        testSupply();
        print_verdict();
    end
endmodule : ogd_fault_logic_test
